// ===== core/gpi_cfg.svh
// Purpose: named offsets, field positions, codes and timing for the pin and regulator block
// Assumes: 50 MHz clock, 8-bit registers at their printed offsets
// Notes: definitions only
`ifndef GPI_CFG_SVH
`define GPI_CFG_SVH

`define ADDR_STATUS   8'h50
`define ADDR_DEBOUNCE 8'h56
`define ADDR_PINS_01  8'h58
`define ADDR_PINS_23  8'h59
`define ADDR_PIN_4    8'h5A
`define ADDR_REG_A    8'h5D
`define ADDR_REG_B    8'h5E

`define RESET_BYTE    8'h00
`define NIB_MODE      3
`define NIB_TYPE      2
`define NIB_FN_MSB    1
`define NIB_FN_LSB    0
`define RG_VSRC_MSB   6
`define RG_VSRC_LSB   5
`define RG_VSEL       4
`define RG_PD_OFF     3
`define RG_ESRC_MSB   2
`define RG_ESRC_LSB   1
`define RG_ON         0
`define DEB_MSB       2

`define FN_GPI        2'h0
`define FN_TRACK      2'h1
`define FN_OPEN_DRAIN 2'h2
`define FN_PUSH_PULL  2'h3
`define SRC_NONE      2'h0

`define CLK_MHZ       50
`define TICK_US       100
`define DEB_US_1      100
`define DEB_US_2      1000
`define DEB_US_3      10000
`define DEB_US_4      50000
`define DEB_US_5      250000
`define DEB_US_6      500000
`define DEB_US_7      1000000
`define DEB_CNT_W     14

`endif

// ===== core/gpi_pkg.sv
// Purpose: shared types for the pin and regulator block
// Assumes: gpi_cfg.svh supplies the numbers
// Notes: types only
`default_nettype none
package gpi_pkg;
  typedef logic [7:0] byte_type;      // one register byte
  typedef logic [3:0] pin_cfg_type;   // {mode, polarity, function}
  typedef logic [1:0] sel_code_type;  // two-bit source selector
endpackage
`default_nettype wire

// ===== core/debounce_if.sv
// Purpose: carrier between the control block and its debouncer
// Assumes: one clock domain
// Notes: raw is already synchronised
`timescale 1ns/1ps
`default_nettype none
interface debounce_if #(parameter int N = 5, parameter int CW = 14);
  logic [N-1:0]  raw;      // synchronised pin levels
  logic [N-1:0]  bypass;   // pass level straight through
  logic          tick;     // one pulse per time base
  logic [CW-1:0] limit;    // ticks a change must hold
  logic [N-1:0]  settled;  // filtered levels
  modport owner  (output raw, bypass, tick, limit, input settled);
  modport filter (input raw, bypass, tick, limit, output settled);
endinterface // debounce_if
`default_nettype wire

// ===== core/pin_debouncer.sv
// Purpose: per-pin debounce filter counting time-base ticks
// Assumes: raw already synchronised, tick one cycle wide
// Notes: a change must hold for limit ticks without bouncing
`timescale 1ns/1ps
`default_nettype none
module pin_debouncer #(
  parameter int N  = 5,
  parameter int CW = 14
) (
  input  wire logic clk,       // system clock
  input  wire logic rst,       // async reset, high
  debounce_if.filter db        // filter side of carrier
);
  logic [CW-1:0] count [N];    // ticks held per pin

  ////////////////////////////////////////////////////////////////
  // filter: restart on bounce, accept after limit ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      db.settled <= '0;
      for (int i = 0; i < N; i++) count[i] <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (db.bypass[i] || db.limit == '0) begin  // no filtering
          db.settled[i] <= db.raw[i];
          count[i]      <= '0;
        end else if (db.raw[i] == db.settled[i]) begin // bounce back
          count[i] <= '0;
        end else if (db.tick) begin
          if (count[i] + 1'b1 >= db.limit) begin     // held long enough
            db.settled[i] <= db.raw[i];
            count[i]      <= '0;
          end else begin
            count[i] <= count[i] + 1'b1;
          end
        end
      end
    end
  end
endmodule // pin_debouncer
`default_nettype wire

// ===== core/gpi_pin_and_regulator_control.sv
// Purpose: pin configuration, pin outputs and pin control of two regulators
// Assumes: register port with byte address, strobes from same clock domain
// Notes: pins are asynchronous and pass two flip-flops first
`include "gpi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module gpi_pin_and_regulator_control #(
  parameter int TICK_CYCLES = `TICK_US * `CLK_MHZ  // cycles per 0.1 ms tick
) (
  input  wire logic            clk,                // system clock
  input  wire logic            rst,                // async reset, high
  input  wire logic [7:0]      reg_addr,           // register offset
  input  wire gpi_pkg::byte_type reg_wdata,        // write data
  input  wire logic            reg_wr,             // write strobe
  input  wire logic            reg_rd,             // read strobe
  output gpi_pkg::byte_type    reg_rdata,          // read data, registered
  input  wire logic            input_pin_0,        // pin 0 level
  input  wire logic            input_pin_1,        // pin 1 level
  input  wire logic            input_pin_4,        // pin 4 level
  input  wire logic            io_pin_2_in,        // pin 2 level seen
  output logic                 io_pin_2_out,       // pin 2 drive value
  output logic                 io_pin_2_oe,        // pin 2 drive enable
  input  wire logic            io_pin_3_in,        // pin 3 level seen
  output logic                 io_pin_3_out,       // pin 3 drive value
  output logic                 io_pin_3_oe,        // pin 3 drive enable
  output logic                 track_enable,       // pin 0 track function
  output logic [4:0]           pin_event,          // pulse on active edge
  output logic [1:0]           regulator_on,       // a=0, b=1 enabled
  output logic [1:0]           regulator_second,   // second voltage set
  output logic [1:0]           regulator_pulldown  // pull-down connected
);
  import gpi_pkg::*;

  localparam int NP = 5;                   // pin count
  localparam int NR = 2;                   // regulator count
  localparam int TW = $clog2(TICK_CYCLES); // tick divider width

  ////////////////////////////////////////////////////////////////
  // helpers

  // active state from level and polarity bit
  function automatic logic pin_active(input logic lvl, input logic pol);
    pin_active = pol ? lvl : ~lvl;
  endfunction

  // voltage source selector to pin index
  function automatic int vsrc_pin(input sel_code_type code);
    unique case (code)
      2'h1:    vsrc_pin = 1;
      2'h2:    vsrc_pin = 2;
      2'h3:    vsrc_pin = 4;
      default: vsrc_pin = 0;   // 00 never used as a pin
    endcase
  endfunction

  // enable source selector to pin index
  function automatic int esrc_pin(input sel_code_type code);
    unique case (code)
      2'h2:    esrc_pin = 1;
      2'h3:    esrc_pin = 3;
      default: esrc_pin = 0;   // 01 selects pin 0, 00 unused
    endcase
  endfunction

  // debounce code to tick count
  function automatic logic [`DEB_CNT_W-1:0] deb_ticks(input logic [`DEB_MSB:0] code);
    unique case (code)
      3'h0:    deb_ticks = '0;
      3'h1:    deb_ticks = `DEB_CNT_W'(`DEB_US_1 / `TICK_US);
      3'h2:    deb_ticks = `DEB_CNT_W'(`DEB_US_2 / `TICK_US);
      3'h3:    deb_ticks = `DEB_CNT_W'(`DEB_US_3 / `TICK_US);
      3'h4:    deb_ticks = `DEB_CNT_W'(`DEB_US_4 / `TICK_US);
      3'h5:    deb_ticks = `DEB_CNT_W'(`DEB_US_5 / `TICK_US);
      3'h6:    deb_ticks = `DEB_CNT_W'(`DEB_US_6 / `TICK_US);
      default: deb_ticks = `DEB_CNT_W'(`DEB_US_7 / `TICK_US);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // register storage

  pin_cfg_type          pin_cfg [NP];     // per-pin config nibble
  logic [`DEB_MSB:0]    debounce_code;    // shared debounce time
  byte_type             reg_ctrl [NR];    // regulator control bytes
  logic [TW-1:0]        tick_count;       // time base divider
  logic                 tick;             // 0.1 ms enable pulse
  logic [NP-1:0]        pin_meta;         // first sync stage
  logic [NP-1:0]        pin_sync;         // second sync stage
  logic [NP-1:0]        active_q;         // previous active state
  logic [NP-1:0]        pin_active_now;   // corrected live state
  logic [NP-1:0]        rise;             // passive to active
  logic [NP-1:0]        fall;             // active to passive
  logic [NP-1:0]        level;            // debounced pin level
  logic [NP-1:0]        filter_on;        // debounce requested

  ////////////////////////////////////////////////////////////////
  // address decode
  wire wr_pins_01 = reg_wr && reg_addr == `ADDR_PINS_01;  // pins 0/1
  wire wr_pins_23 = reg_wr && reg_addr == `ADDR_PINS_23;  // pins 2/3
  wire wr_pin_4   = reg_wr && reg_addr == `ADDR_PIN_4;    // pin 4
  wire wr_deb     = reg_wr && reg_addr == `ADDR_DEBOUNCE; // time field
  wire [NR-1:0] wr_reg;                                   // regulator bytes
  assign wr_reg[0] = reg_wr && reg_addr == `ADDR_REG_A;
  assign wr_reg[1] = reg_wr && reg_addr == `ADDR_REG_B;

  // pin 2/3 output modes
  wire out_2 = pin_cfg[2][`NIB_FN_MSB];  // codes 10 and 11 drive
  wire out_3 = pin_cfg[3][`NIB_FN_MSB];

  ////////////////////////////////////////////////////////////////
  // config writes; reset gives general input, no filtering
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) pin_cfg[i] <= '0;
      debounce_code <= '0;
    end else begin
      if (wr_pins_01) begin
        pin_cfg[0] <= reg_wdata[3:0];
        pin_cfg[1] <= reg_wdata[7:4];
      end
      if (wr_pins_23) begin
        pin_cfg[2] <= reg_wdata[3:0];
        pin_cfg[3] <= reg_wdata[7:4];
      end
      if (wr_pin_4) pin_cfg[4] <= reg_wdata[3:0];
      if (wr_deb) debounce_code <= reg_wdata[`DEB_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // time base: one enable pulse per tick period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == TW'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin synchroniser, two stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {input_pin_4, io_pin_3_in, io_pin_2_in, input_pin_1, input_pin_0};
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // debounce filter

  debounce_if #(.N(NP), .CW(`DEB_CNT_W)) deb ();

  // pins in output mode reuse the mode bit as level, so no filter
  assign filter_on[0] = pin_cfg[0][`NIB_MODE];
  assign filter_on[1] = pin_cfg[1][`NIB_MODE];
  assign filter_on[2] = pin_cfg[2][`NIB_MODE] && !out_2;
  assign filter_on[3] = pin_cfg[3][`NIB_MODE] && !out_3;
  assign filter_on[4] = pin_cfg[4][`NIB_MODE];
  assign deb.raw    = pin_sync;
  assign deb.bypass = ~filter_on;
  assign deb.tick   = tick;
  assign deb.limit  = deb_ticks(debounce_code);
  assign level      = deb.settled;

  pin_debouncer #(.N(NP), .CW(`DEB_CNT_W)) u_debouncer (
    .clk (clk),
    .rst (rst),
    .db  (deb)
  );

  ////////////////////////////////////////////////////////////////
  // polarity correction and edge detection
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_active
      // each pin judged by its own polarity bit
      assign pin_active_now[gp] = pin_active(level[gp], pin_cfg[gp][`NIB_TYPE]);
    end
  endgenerate
  assign rise = pin_active_now & ~active_q;
  assign fall = ~pin_active_now & active_q;

  // active_q starts set: reset config is active low with level 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_q  <= '1;
      pin_event <= '0;
    end else begin
      active_q  <= pin_active_now;
      pin_event <= rise;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin 2/3 drivers and track output
  wire drive_2 = ~(pin_cfg[2][`NIB_MODE] ^ pin_cfg[2][`NIB_TYPE]);
  wire drive_3 = ~(pin_cfg[3][`NIB_MODE] ^ pin_cfg[3][`NIB_TYPE]);
  wire pp_2    = pin_cfg[2][`NIB_FN_MSB:`NIB_FN_LSB] == `FN_PUSH_PULL;
  wire pp_3    = pin_cfg[3][`NIB_FN_MSB:`NIB_FN_LSB] == `FN_PUSH_PULL;
  wire track_w = pin_cfg[0][`NIB_FN_MSB:`NIB_FN_LSB] == `FN_TRACK;

  // open drain drives low only; push-pull drives both levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_pin_2_out <= 1'b0;
      io_pin_2_oe  <= 1'b0;
      io_pin_3_out <= 1'b0;
      io_pin_3_oe  <= 1'b0;
      track_enable <= 1'b0;
    end else begin
      io_pin_2_out <= pp_2 ? drive_2 : 1'b0;
      io_pin_2_oe  <= out_2 && (pp_2 || !drive_2);
      io_pin_3_out <= pp_3 ? drive_3 : 1'b0;
      io_pin_3_oe  <= out_3 && (pp_3 || !drive_3);
      track_enable <= track_w && pin_active_now[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // regulator control
  logic [NR-1:0] next_on;      // next enable state
  logic [NR-1:0] next_second;  // next voltage choice

  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_reg
      wire sel_code_type vsrc = reg_ctrl[gr][`RG_VSRC_MSB:`RG_VSRC_LSB];
      wire sel_code_type esrc = reg_ctrl[gr][`RG_ESRC_MSB:`RG_ESRC_LSB];
      wire v_rise = vsrc != `SRC_NONE && rise[vsrc_pin(vsrc)];
      wire v_fall = vsrc != `SRC_NONE && fall[vsrc_pin(vsrc)];
      wire e_rise = esrc != `SRC_NONE && rise[esrc_pin(esrc)];
      wire e_fall = esrc != `SRC_NONE && fall[esrc_pin(esrc)];

      // pin edges win over a write in the same cycle
      assign next_on[gr] = e_rise ? 1'b1 :
                           e_fall ? 1'b0 :
                           wr_reg[gr] ? reg_wdata[`RG_ON] :
                           reg_ctrl[gr][`RG_ON];
      assign next_second[gr] = v_rise ? 1'b1 :
                               v_fall ? 1'b0 :
                               wr_reg[gr] ? reg_wdata[`RG_VSEL] :
                               reg_ctrl[gr][`RG_VSEL];

      // control byte; bit 7 reserved and held zero
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          reg_ctrl[gr] <= `RESET_BYTE;
        end else begin
          if (wr_reg[gr]) begin
            reg_ctrl[gr][`RG_VSRC_MSB:`RG_VSRC_LSB] <= reg_wdata[`RG_VSRC_MSB:`RG_VSRC_LSB];
            reg_ctrl[gr][`RG_PD_OFF]                <= reg_wdata[`RG_PD_OFF];
            reg_ctrl[gr][`RG_ESRC_MSB:`RG_ESRC_LSB] <= reg_wdata[`RG_ESRC_MSB:`RG_ESRC_LSB];
          end
          reg_ctrl[gr][`RG_ON]   <= next_on[gr];
          reg_ctrl[gr][`RG_VSEL] <= next_second[gr];
        end
      end

      // outputs follow the stored state
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regulator_on[gr]       <= 1'b0;
          regulator_second[gr]   <= 1'b0;
          regulator_pulldown[gr] <= 1'b0;
        end else begin
          regulator_on[gr]       <= reg_ctrl[gr][`RG_ON];
          regulator_second[gr]   <= reg_ctrl[gr][`RG_VSEL];
          regulator_pulldown[gr] <= !reg_ctrl[gr][`RG_ON] && !reg_ctrl[gr][`RG_PD_OFF];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  byte_type rd_mux;  // selected read byte
  always_comb begin
    unique case (reg_addr)
      `ADDR_STATUS:   rd_mux = {3'h0, level};
      `ADDR_DEBOUNCE: rd_mux = {5'h00, debounce_code};
      `ADDR_PINS_01:  rd_mux = {pin_cfg[1], pin_cfg[0]};
      `ADDR_PINS_23:  rd_mux = {pin_cfg[3], pin_cfg[2]};
      `ADDR_PIN_4:    rd_mux = {4'h0, pin_cfg[4]};
      `ADDR_REG_A:    rd_mux = reg_ctrl[0];
      `ADDR_REG_B:    rd_mux = reg_ctrl[1];
      default:        rd_mux = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) reg_rdata <= `RESET_BYTE;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

endmodule // gpi_pin_and_regulator_control
`default_nettype wire

// ===== tb/gpi_checker.sv
// Purpose: port-level assertions for the pin and regulator block
// Assumes: one clock domain, config shadows follow register writes
// Notes: bound to the block's top module at the file foot
`timescale 1ns/1ps
`default_nettype none
module gpi_checker (
  input  wire logic              clk,                // system clock
  input  wire logic              rst,                // async reset, high
  input  wire logic [7:0]        reg_addr,           // register offset
  input  wire gpi_pkg::byte_type reg_wdata,          // write data
  input  wire logic              reg_wr,             // write strobe
  input  wire logic              reg_rd,             // read strobe
  input  wire gpi_pkg::byte_type reg_rdata,          // read data
  input  wire logic              io_pin_2_out,       // pin 2 drive value
  input  wire logic              io_pin_2_oe,        // pin 2 drive enable
  input  wire logic              io_pin_3_out,       // pin 3 drive value
  input  wire logic              io_pin_3_oe,        // pin 3 drive enable
  input  wire logic              track_enable,       // pin 0 track output
  input  wire logic [4:0]        pin_event,          // active edge pulses
  input  wire logic [1:0]        regulator_on,       // regulators enabled
  input  wire logic [1:0]        regulator_second,   // second set chosen
  input  wire logic [1:0]        regulator_pulldown  // pull-down connected
);
  import gpi_pkg::*;
  byte_type c01;  // shadow of pins 0/1 config
  byte_type c23;  // shadow of pins 2/3 config
  byte_type ca;   // shadow of regulator a control
  logic     e_oe2, e_out2, e_oe3, e_out3, trk_fn;  // expected drive
  // shadows follow host writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c01 <= 8'h00;
      c23 <= 8'h00;
      ca  <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h58) c01 <= reg_wdata;
      if (reg_addr == 8'h59) c23 <= reg_wdata;
      if (reg_addr == 8'h5D) ca <= reg_wdata;
    end
  end
  // drive expected: push-pull always, open-drain only when low
  assign e_oe2  = c23[1] && (c23[0] || c23[3] != c23[2]);
  assign e_out2 = c23[1:0] == 2'h3 && c23[3] == c23[2];
  assign e_oe3  = c23[5] && (c23[4] || c23[7] != c23[6]);
  assign e_out3 = c23[5:4] == 2'h3 && c23[7] == c23[6];
  assign trk_fn = c01[1:0] == 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  AST_P2_DRIVE: assert property (io_pin_2_oe == $past(e_oe2) && io_pin_2_out == $past(e_out2))
    else $error("pin 2 drive wrong");
  AST_P3_DRIVE: assert property (io_pin_3_oe == $past(e_oe3) && io_pin_3_out == $past(e_out3))
    else $error("pin 3 drive wrong");
  AST_PULLDOWN: assert property ((regulator_pulldown & regulator_on) == 2'h0)
    else $error("pull-down on a running regulator");
  AST_EVT_PULSE: assert property ((pin_event & $past(pin_event)) == 5'h00)
    else $error("pin event longer than one cycle");
  AST_SW_ON: assert property (reg_wr && reg_addr == 8'h5D && reg_wdata[2:1] == 2'h0
    |-> ##2 regulator_on[0] == $past(reg_wdata[0], 2)) else $error("enable bit not followed");
  AST_SW_SECOND: assert property (reg_wr && reg_addr == 8'h5E && reg_wdata[6:5] == 2'h0
    |-> ##2 regulator_second[1] == $past(reg_wdata[4], 2)) else $error("select bit not followed");
  AST_UNMAPPED: assert property (reg_rd && !(reg_addr inside {8'h50, 8'h56, 8'h58, 8'h59, 8'h5A,
    8'h5D, 8'h5E}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_EN_EDGE: assert property (ca[2:1] == 2'h1 && pin_event[0] |=> regulator_on[0])
    else $error("enable edge missed");
  AST_TRACK: assert property (track_enable |-> $past(trk_fn))
    else $error("track without function");
  COV_EDGE: cover property (ca[2:1] == 2'h1 && pin_event[0]);
  COV_OD: cover property (io_pin_2_oe && !io_pin_2_out);
  COV_TRACK: cover property (track_enable);
endmodule // gpi_checker
bind gpi_pin_and_regulator_control gpi_checker gpi_checker_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .io_pin_2_out, .io_pin_2_oe, .io_pin_3_out, .io_pin_3_oe, .track_enable, .pin_event,
  .regulator_on, .regulator_second, .regulator_pulldown);
`default_nettype wire

// ===== tb/pin_side_model.sv
// Purpose: system logic standing on the pins
// Assumes: pins 2/3 carry a pull-up
// Notes: bench releases pins 2/3 while the block drives them
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
  input  wire logic [4:0] lvl,     // wanted pin levels
  input  wire logic [1:0] ext_en,  // system drives pin 2, 3
  input  wire logic       out2,    // block value pin 2
  input  wire logic       oe2,     // block enable pin 2
  input  wire logic       out3,    // block value pin 3
  input  wire logic       oe3,     // block enable pin 3
  output logic [2:0]      gin,     // pins 4, 1, 0
  output logic            w2,      // pin 2 wire
  output logic            w3       // pin 3 wire
);
  // input-only pins follow system logic
  assign gin = {lvl[4], lvl[1], lvl[0]};
  // wire: block drive, else system, else pull-up
  assign w2 = oe2 ? out2 : (ext_en[0] ? lvl[2] : 1'b1);
  assign w3 = oe3 ? out3 : (ext_en[1] ? lvl[3] : 1'b1);
endmodule // pin_side_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: register and pin sequences for the pin and regulator block
// Assumes: inputs change at the falling edge, tick every 4 cycles
// Notes: waits follow the documented pin-to-output latency
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpi_pkg::*;
  logic       clk = 1'b0;  // 50 MHz
  logic       rst = 1'b1;  // async reset
  logic [7:0] reg_addr;    // offset
  byte_type   reg_wdata;   // write data
  byte_type   reg_rdata;   // read data
  logic       reg_wr, reg_rd;                     // strobes
  logic [4:0] lvl;                                // pin levels wanted
  logic [1:0] ext_en;                             // system drives 2/3
  logic [2:0] gin;                                // pins 4,1,0
  logic       w2, w3, out2, oe2, out3, oe3, trk;  // pin 2/3 wires, track output
  logic [4:0] evt;                                // events
  logic [1:0] r_on, r_sec, r_pd;                  // regulator outputs
  logic [3:0] nb;                                 // pin 2/3 nibble
  logic       eo, eout;                           // expected drive
  int         n_mismatch = 0;                     // mismatches
  int         n_compared = 0;                     // comparisons
  int         n_evt = 0;                          // event pulses seen
  int         evt_snap;                           // event count at test start
  logic [7:0] raddr [9] = '{8'h58, 8'h59, 8'h5A, 8'h5D, 8'h5E, 8'h56, 8'h50, 8'h57, 8'h00};
  int         ep [3] = '{0, 1, 3};                // enable source pins
  int         vp [3] = '{1, 2, 4};                // voltage source pins
  // clock
  always #10 clk = ~clk;
  // count one-cycle event pulses on every pin
  always @(posedge clk) n_evt <= n_evt + $countones(evt);
  gpi_pin_and_regulator_control #(.TICK_CYCLES(4)) gpi_pin_and_regulator_control_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_pin_0(gin[0]), .input_pin_1(gin[1]), .input_pin_4(gin[2]), .io_pin_2_in(w2), .io_pin_2_out(out2),
    .io_pin_2_oe(oe2), .io_pin_3_in(w3), .io_pin_3_out(out3), .io_pin_3_oe(oe3), .track_enable(trk),
    .pin_event(evt), .regulator_on(r_on), .regulator_second(r_sec), .regulator_pulldown(r_pd));
  pin_side_model pin_side_model_i (.lvl(lvl), .ext_en(ext_en), .out2(out2), .oe2(oe2), .out3(out3),
    .oe3(oe3), .gin(gin), .w2(w2), .w3(w3));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // write, then let outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(2);
  endtask
  // read, compare once the registered data stands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    chk(reg_rdata, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  // main sequence
  initial begin
    {lvl, ext_en, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    ext_en = 2'h3;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cyc(4);
    foreach (raddr[i]) rd(raddr[i], 8'h00);
    chk(8'(r_pd), 8'h03);
    $display("test reset done");
    wr(8'h5D, 8'hF9);
    chk(8'(r_on), 8'h01);
    rd(8'h5D, 8'h79);
    wr(8'h5D, 8'h00);
    chk(8'(r_pd), 8'h03);
    wr(8'h5D, 8'h08);
    chk(8'(r_pd), 8'h02);
    wr(8'h5A, 8'hFC);
    rd(8'h5A, 8'h0C);
    wr(8'h50, 8'h1F);
    rd(8'h50, 8'h00);
    wr(8'h56, 8'hFF);
    rd(8'h56, 8'h07);
    wr(8'h56, 8'h00);
    wr(8'h58, 8'hCD);
    rd(8'h58, 8'hCD);
    wr(8'h58, 8'h00);
    $display("test registers done");
    ext_en = 2'h0;
    for (int k = 0; k < 8; k++) begin
      nb   = {k[1], k[0], 1'b1, k[2]};
      eo   = k[2] | (k[1] != k[0]);
      eout = k[2] & (k[1] == k[0]);
      wr(8'h59, {nb, nb});
      chk({4'h0, oe3, out3, oe2, out2}, {4'h0, eo, eout, eo, eout});
      cyc(3);
      rd(8'h50, {4'h0, k[1] == k[0], k[1] == k[0], 2'h0});
    end
    wr(8'h59, 8'h00);
    chk({4'h0, oe3, out3, oe2, out2}, 8'h00);
    ext_en = 2'h3;
    $display("test pin drive done");
    wr(8'h58, 8'h44);
    wr(8'h59, 8'h40);
    for (int k = 0; k < 3; k++) begin
      wr(8'h5D, {5'h00, 2'(k + 1), 1'b0});
      lvl[ep[k]] = 1'b1;
      cyc(5);
      chk(8'(r_on), 8'h01);
      lvl[ep[k]] = 1'b0;
      cyc(5);
      chk(8'(r_on), 8'h00);
    end
    wr(8'h58, 8'h00);
    lvl[0] = 1'b1;
    cyc(5);
    wr(8'h5E, 8'h02);
    lvl[0] = 1'b0;
    cyc(5);
    chk(8'(r_on), 8'h02);
    lvl[0] = 1'b1;
    cyc(5);
    chk(8'(r_on), 8'h00);
    wr(8'h5E, 8'h00);
    wr(8'h58, 8'h05);
    cyc(5);
    chk(8'(trk), 8'h01);
    wr(8'h58, 8'h00);
    cyc(2);
    chk(8'(trk), 8'h00);
    lvl[0] = 1'b0;
    $display("test enable sources done");
    wr(8'h58, 8'h40);
    wr(8'h59, 8'h04);
    wr(8'h5A, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(8'h5E, {1'b0, 2'(k + 1), 5'h00});
      lvl[vp[k]] = 1'b1;
      cyc(5);
      chk(8'(r_sec), 8'h02);
      lvl[vp[k]] = 1'b0;
      cyc(5);
      chk(8'(r_sec), 8'h00);
    end
    wr(8'h5E, 8'h10);
    chk(8'(r_sec), 8'h02);
    wr(8'h5E, 8'h00);
    $display("test voltage sources done");
    wr(8'h56, 8'h02);
    wr(8'h58, 8'h0C);
    wr(8'h5D, 8'h02);
    evt_snap = n_evt;
    lvl[0] = 1'b1;
    cyc(8);
    lvl[0] = 1'b0;
    cyc(60);
    chk(8'(r_on), 8'h00);
    chk(8'(n_evt - evt_snap), 8'h00);
    lvl[0] = 1'b1;
    cyc(70);
    chk(8'(r_on), 8'h01);
    chk(8'(n_evt - evt_snap), 8'h01);
    $display("test debounce done");
    close_out;
  end
endmodule // tb_top
`default_nettype wire
